// [rtl/and_branch_exec.sv]
// decode and execute of logical AND forms and short conditional branches
// assumes fetch presents one byte per valid, memory answers in the same cycle as the read strobe
`timescale 1ns/100ps
// Summary of operation
// - AND destination with source, write destination
// - accumulator form: byte or word immediate
// - 001000dW with mod/reg/rm, optional displacement
// - 1000000W sub 100, immediate after displacement
// - sign-bit immediate form takes one byte
// - lengths follow form, mod and width
// - taken branch adds sign-extended disp8 to pc
// - target spans -128 to +127 in segment
// - not taken: pc stays on next instruction
// - carry branch when carry set
// - count-zero branch, count register unchanged
// - equal branch when zero flag set
// - ge branch when sign xor overflow clear
// - greater branch when zero or xor clear
// - le branch when zero or xor set
// - above branch when carry or zero clear
module and_branch_exec
   import and_branch_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        byte_valid_i,
   input  wire logic [7:0]  byte_i,
   output logic             byte_take_o,
   input  wire logic [15:0] reg_rd_data_i,
   input  wire logic [15:0] count_register_i,
   input  wire logic        carry_flag_i,
   input  wire logic        zero_flag_i,
   input  wire logic        sign_flag_i,
   input  wire logic        ovf_flag_i,
   input  wire logic [15:0] mem_rd_data_i,
   output logic [2:0]       reg_rd_idx_o,
   output logic             reg_wr_o,
   output logic [2:0]       reg_wr_idx_o,
   output logic             reg_wr_word_o,
   output logic [15:0]      reg_wr_data_o,
   output logic             mem_rd_o,
   output logic             mem_wr_o,
   output logic             mem_word_o,
   output logic [1:0]       mem_mod_o,
   output logic [2:0]       mem_rm_o,
   output logic [15:0]      mem_disp_o,
   output logic [15:0]      mem_wr_data_o,
   output logic             flag_wr_o,
   output logic             carry_flag_o,
   output logic             ovf_flag_o,
   output logic             zero_flag_o,
   output logic             sign_flag_o,
   output logic             parity_flag_o,
   output logic [15:0]      program_counter_o,
   output logic             branch_taken_o,
   output logic             illegal_o,
   output logic [2:0]       insn_len_o,
   output logic             done_o
);
   // ==========================================
   // state
   state_t      state_ff, nxt_state;
   logic [7:0]  op_ff;
   logic [7:0]  modrm_ff;
   logic [15:0] disp_ff, imm_ff;
   logic [1:0]  disp_cnt_ff, imm_cnt_ff;
   logic        disp_hi_ff, imm_hi_ff;
   logic [15:0] pc_ff;
   logic [2:0]  len_ff;
   logic [15:0] mem_val_ff;
   logic        reg_wr_ff, mem_rd_ff, mem_wr_ff, flag_wr_ff, taken_ff, ill_ff, done_ff;
   logic [15:0] wr_data_ff;
   logic        z_ff, s_ff, p_ff;

   // ==========================================
   // decode of first byte and modrm
   wire logic       take      = byte_valid_i && (state_ff == ST_OP || state_ff == ST_MODRM ||
                                               state_ff == ST_DISP || state_ff == ST_IMM);
   wire logic       is_rm     = (op_ff & OP_AND_RM_MASK) == OP_AND_RM;
   wire logic       is_acc    = (op_ff & OP_AND_ACC_MASK) == OP_AND_ACC;
   wire logic       is_grp    = ((op_ff & OP_IMM_MASK) == OP_IMM_GRP) ||
                                ((op_ff & OP_IMM_MASK) == OP_IMM_SHORT);
   wire logic       is_short  = op_ff[BIT_S] && is_grp;
   wire logic       wbit      = op_ff[BIT_W];
   wire logic       dbit      = op_ff[BIT_D];
   wire logic [1:0] md        = modrm_ff[7:6];
   wire logic [2:0] mid       = modrm_ff[5:3];
   wire logic [2:0] rm        = modrm_ff[2:0];
   // only the listed branches; other 7x codes fall to illegal
   wire logic       is_br     = (op_ff == OP_JC) || (op_ff == OP_JNC) || (op_ff == OP_JZ) ||
                                (op_ff == OP_JA) || (op_ff == OP_JS) || (op_ff == OP_JL) ||
                                (op_ff == OP_JGE) || (op_ff == OP_JLE) || (op_ff == OP_JG) ||
                                (op_ff == OP_JCXZ);
   wire logic       op_is_rm  = (byte_i & OP_AND_RM_MASK) == OP_AND_RM;
   wire logic       op_is_acc = (byte_i & OP_AND_ACC_MASK) == OP_AND_ACC;
   wire logic       op_is_grp = ((byte_i & OP_IMM_MASK) == OP_IMM_GRP) ||
                                ((byte_i & OP_IMM_MASK) == OP_IMM_SHORT);
   wire logic       op_is_br  = (byte_i == OP_JC) || (byte_i == OP_JNC) || (byte_i == OP_JZ) ||
                                (byte_i == OP_JA) || (byte_i == OP_JS) || (byte_i == OP_JL) ||
                                (byte_i == OP_JGE) || (byte_i == OP_JLE) || (byte_i == OP_JG) ||
                                (byte_i == OP_JCXZ);
   // displacement byte count from mod/rm
   wire logic [1:0] mb_disp   = (byte_i[7:6] == MOD_D8) ? 2'd1 :
                                (byte_i[7:6] == MOD_D16) ? 2'd2 :
                                (byte_i[7:6] == MOD_NONE && byte_i[2:0] == RM_DIRECT) ? 2'd2 : 2'd0;
   wire logic [1:0] imm_need  = is_br ? 2'd1 : (is_short || !wbit) ? 2'd1 : 2'd2;
   wire logic       grp_bad   = is_grp && (byte_i[5:3] != SUB_AND);

   // ==========================================
   // branch conditions
   wire logic sv  = sign_flag_i ^ ovf_flag_i;
   wire logic cond =
      (op_ff == OP_JC)   ?  carry_flag_i :
      (op_ff == OP_JNC)  ? !carry_flag_i :
      (op_ff == OP_JZ)   ?  zero_flag_i :
      (op_ff == OP_JA)   ? !(carry_flag_i | zero_flag_i) :
      (op_ff == OP_JS)   ?  sign_flag_i :
      (op_ff == OP_JL)   ?  sv :
      (op_ff == OP_JGE)  ? !sv :
      (op_ff == OP_JLE)  ?  (zero_flag_i | sv) :
      (op_ff == OP_JG)   ? !(zero_flag_i | sv) :
      (count_register_i == 16'h0000);
   // 16-bit wrap keeps the target inside the current segment
   wire logic [15:0] pc_next = pc_ff + {13'h0000, len_ff};
   wire logic [15:0] br_tgt  = pc_next + {{8{imm_ff[7]}}, imm_ff[7:0]};

   // ==========================================
   // operand selection for the AND
   wire logic        rm_is_reg = (md == MOD_REG);
   wire logic [15:0] rm_val    = rm_is_reg ? reg_rd_data_i : mem_val_ff;
   wire logic [15:0] imm_ext   = (is_short && wbit) ? {{8{imm_ff[7]}}, imm_ff[7:0]} : imm_ff;
   wire logic [15:0] a_dst     = is_acc ? reg_rd_data_i : rm_val;
   wire logic [15:0] a_src     = (is_acc || is_grp) ? imm_ext : reg_rd_data_i;
   logic [15:0] alu_res;
   logic        alu_z, alu_s, alu_p;
   // second read of the reg field is avoided: ports carry one register read
   logic [15:0] reg_hold_ff;
   wire logic [15:0] src2 = is_rm ? reg_hold_ff : a_src;

   and_flag_unit u_and
   (
      .word_i   (wbit),
      .dst_i    (a_dst),
      .src_i    (src2),
      .res_o    (alu_res),
      .zero_o   (alu_z),
      .sign_o   (alu_s),
      .parity_o (alu_p)
   );

   // ==========================================
   // sequencer
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OP:
         begin
            if (byte_valid_i && op_is_br)
               nxt_state = ST_IMM;
            else if (byte_valid_i && (op_is_rm || op_is_grp))
               nxt_state = ST_MODRM;
            else if (byte_valid_i && op_is_acc)
               nxt_state = ST_IMM;
            else if (byte_valid_i)
               nxt_state = ST_EXEC;
         end
         ST_MODRM:
         begin
            if (byte_valid_i && grp_bad)
               nxt_state = ST_EXEC;
            else if (byte_valid_i && mb_disp != 2'd0)
               nxt_state = ST_DISP;
            else if (byte_valid_i && is_grp)
               nxt_state = ST_IMM;
            else if (byte_valid_i)
               nxt_state = (byte_i[7:6] == MOD_REG) ? ST_EXEC : ST_MEM;
         end
         ST_DISP:
            if (byte_valid_i && disp_cnt_ff == 2'd1)
               nxt_state = is_grp ? ST_IMM : ST_MEM;
         ST_IMM:
            if (byte_valid_i && imm_cnt_ff == 2'd1)
               nxt_state = (is_grp && !rm_is_reg) ? ST_MEM : ST_EXEC;
         ST_MEM:  nxt_state = ST_EXEC;
         ST_EXEC: nxt_state = ST_OP;
         default: nxt_state = ST_OP;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         state_ff <= ST_OP;
         op_ff <= 8'h00;
         modrm_ff <= 8'h00;
         disp_ff <= 16'h0000;
         imm_ff <= 16'h0000;
         disp_cnt_ff <= 2'd0;
         imm_cnt_ff <= 2'd0;
         disp_hi_ff <= 1'b0;
         imm_hi_ff <= 1'b0;
         len_ff <= 3'd0;
         mem_val_ff <= 16'h0000;
         reg_hold_ff <= 16'h0000;
      end
      else
      begin
         state_ff <= nxt_state;
         if (take)
            len_ff <= (state_ff == ST_OP) ? 3'd1 : len_ff + 3'd1;
         if (take && state_ff == ST_OP)
         begin
            op_ff <= byte_i;
            modrm_ff <= {MOD_REG, 3'h0, ACC_IDX};
            imm_hi_ff <= 1'b0;
            disp_hi_ff <= 1'b0;
            imm_ff <= 16'h0000;
            disp_ff <= 16'h0000;
            imm_cnt_ff <= (op_is_acc && byte_i[BIT_W]) ? 2'd2 : 2'd1;
         end
         if (take && state_ff == ST_MODRM)
         begin
            modrm_ff <= byte_i;
            disp_cnt_ff <= mb_disp;
            imm_cnt_ff <= imm_need;
            reg_hold_ff <= reg_rd_data_i;
         end
         if (take && state_ff == ST_DISP)
         begin
            disp_cnt_ff <= disp_cnt_ff - 2'd1;
            disp_hi_ff <= 1'b1;
            if (disp_hi_ff)
               disp_ff[15:8] <= byte_i;
            else
               disp_ff <= (md == MOD_D8) ? {{8{byte_i[7]}}, byte_i} : {8'h00, byte_i};
         end
         if (take && state_ff == ST_IMM)
         begin
            imm_cnt_ff <= imm_cnt_ff - 2'd1;
            imm_hi_ff <= 1'b1;
            if (imm_hi_ff)
               imm_ff[15:8] <= byte_i;
            else
               imm_ff[7:0] <= byte_i;
         end
         if (state_ff == ST_MEM)
            mem_val_ff <= mem_rd_data_i;
      end
   end

   // ==========================================
   // outputs; strobes, data, zero/sign/parity flags and pc registered, carry and overflow tied low, byte take, indices and width combinational
   wire logic exec     = (state_ff == ST_EXEC);
   wire logic and_op   = is_rm || is_acc || (is_grp && mid == SUB_AND);
   wire logic to_reg   = is_acc || (rm_is_reg && !(is_rm && dbit)) || (is_rm && dbit);
   wire logic [2:0] wr_idx = is_acc ? ACC_IDX : (is_rm && dbit) ? mid : rm;
   wire logic [2:0] rd_idx = (state_ff == ST_MODRM) ? byte_i[5:3] :
                             is_acc ? ACC_IDX : rm;                                    // reg field already held

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         pc_ff <= PC_RESET;
         reg_wr_ff <= 1'b0;
         mem_rd_ff <= 1'b0;
         mem_wr_ff <= 1'b0;
         flag_wr_ff <= 1'b0;
         taken_ff <= 1'b0;
         ill_ff <= 1'b0;
         done_ff <= 1'b0;
         wr_data_ff <= 16'h0000;
         z_ff <= 1'b0;
         s_ff <= 1'b0;
         p_ff <= 1'b0;
      end
      else
      begin
         reg_wr_ff <= exec && and_op && !is_br && to_reg;
         mem_wr_ff <= exec && and_op && !is_br && !to_reg;
         mem_rd_ff <= (nxt_state == ST_MEM);
         flag_wr_ff <= exec && and_op && !is_br;
         taken_ff <= exec && is_br && cond;
         ill_ff <= exec && !and_op && !is_br;
         done_ff <= exec;
         if (exec)
         begin
            pc_ff <= (is_br && cond) ? br_tgt : pc_next;
            wr_data_ff <= alu_res;
            z_ff <= alu_z;
            s_ff <= alu_s;
            p_ff <= alu_p;
         end
      end
   end

   assign byte_take_o       = take;
   assign reg_rd_idx_o      = rd_idx;
   assign reg_wr_o          = reg_wr_ff;
   assign reg_wr_idx_o      = wr_idx;
   assign reg_wr_word_o     = wbit;
   assign reg_wr_data_o     = wr_data_ff;
   assign mem_rd_o          = mem_rd_ff;
   assign mem_wr_o          = mem_wr_ff;
   assign mem_word_o        = wbit;
   assign mem_mod_o         = md;
   assign mem_rm_o          = rm;
   assign mem_disp_o        = disp_ff;
   assign mem_wr_data_o     = wr_data_ff;
   assign flag_wr_o         = flag_wr_ff;
   assign carry_flag_o      = 1'b0;
   assign ovf_flag_o        = 1'b0;
   assign zero_flag_o       = z_ff;
   assign sign_flag_o       = s_ff;
   assign parity_flag_o     = p_ff;
   assign program_counter_o = pc_ff;
   assign branch_taken_o    = taken_ff;
   assign illegal_o         = ill_ff;
   assign insn_len_o        = len_ff;
   assign done_o            = done_ff;

   // ==========================================
   // checks
   a_flags_after_and : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      flag_wr_o |-> (carry_flag_o == 1'b0 && ovf_flag_o == 1'b0 &&
                     zero_flag_o == (reg_wr_data_o == 16'h0000)))
      else $error("and left carry or overflow set");
   a_branch_no_flags : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      branch_taken_o |-> !flag_wr_o && !reg_wr_o)
      else $error("branch wrote flags or register");
   a_taken_target : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && is_br && cond) |=> program_counter_o == $past(br_tgt))
      else $error("taken branch target wrong");
   a_not_taken_pc : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && is_br && !cond) |=> program_counter_o == $past(pc_next) && !branch_taken_o)
      else $error("untaken branch moved pc wrongly");
   a_carry_branch : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && op_ff == OP_JC) |=> branch_taken_o == $past(carry_flag_i))
      else $error("carry branch decision wrong");
   a_count_zero : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && op_ff == OP_JCXZ) |=> branch_taken_o == ($past(count_register_i) == 16'h0000))
      else $error("count-zero decision wrong");
   a_greater_branch : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && op_ff == OP_JG) |=> branch_taken_o ==
         !($past(zero_flag_i) | ($past(sign_flag_i) ^ $past(ovf_flag_i))))
      else $error("greater branch decision wrong");
   a_branch_length : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && is_br) |-> len_ff == 3'd2)
      else $error("short branch not two bytes");
   a_and_length : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (exec && and_op && !is_br) |-> (len_ff >= 3'd2 && len_ff <= 3'd6))
      else $error("and length out of range");
endmodule : and_branch_exec

// [rtl/and_branch_pkg.sv]
// constants for the logical-product and short-branch execute block
// assumes a byte-wide fetch stream and a 16-bit register file outside
package and_branch_pkg;
   // ==========================================
   // opcode patterns
   localparam logic [7:0] OP_AND_RM_MASK = 8'hfc;
   localparam logic [7:0] OP_AND_RM      = 8'h20;
   localparam logic [7:0] OP_AND_ACC_MASK = 8'hfe;
   localparam logic [7:0] OP_AND_ACC     = 8'h24;
   localparam logic [7:0] OP_IMM_MASK    = 8'hfc;
   localparam logic [7:0] OP_IMM_GRP     = 8'h80;
   localparam logic [7:0] OP_IMM_SHORT   = 8'h82;
   localparam logic [2:0] SUB_AND        = 3'h4;
   localparam logic [7:0] OP_JC          = 8'h72;
   localparam logic [7:0] OP_JNC         = 8'h73;
   localparam logic [7:0] OP_JZ          = 8'h74;
   localparam logic [7:0] OP_JA          = 8'h77;
   localparam logic [7:0] OP_JS          = 8'h78;
   localparam logic [7:0] OP_JL          = 8'h7c;
   localparam logic [7:0] OP_JGE         = 8'h7d;
   localparam logic [7:0] OP_JLE         = 8'h7e;
   localparam logic [7:0] OP_JG          = 8'h7f;
   localparam logic [7:0] OP_JCXZ        = 8'he3;
   // ==========================================
   // field positions
   localparam int BIT_W = 0;
   localparam int BIT_D = 1;
   localparam int BIT_S = 1;
   localparam logic [1:0] MOD_REG  = 2'h3;
   localparam logic [1:0] MOD_D8   = 2'h1;
   localparam logic [1:0] MOD_D16  = 2'h2;
   localparam logic [1:0] MOD_NONE = 2'h0;
   localparam logic [2:0] RM_DIRECT = 3'h6;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [2:0] ACC_IDX   = 3'h0;
   typedef enum logic [2:0] {ST_OP, ST_MODRM, ST_DISP, ST_IMM, ST_MEM, ST_EXEC} state_t;
endpackage : and_branch_pkg

// [rtl/and_flag_unit.sv]
// combinational AND and flag generation for byte and word widths
// assumes operands already aligned in the low bits for byte width
`timescale 1ns/100ps
module and_flag_unit
   import and_branch_pkg::*;
(
   input  wire logic        word_i,
   input  wire logic [15:0] dst_i,
   input  wire logic [15:0] src_i,
   output logic [15:0]      res_o,
   output logic             zero_o,
   output logic             sign_o,
   output logic             parity_o
);
   wire logic [15:0] prod = dst_i & src_i;
   // byte form keeps high byte zero so writers can pick lanes
   assign res_o    = word_i ? prod : {8'h00, prod[7:0]};
   assign zero_o   = word_i ? (prod == 16'h0000) : (prod[7:0] == 8'h00);
   assign sign_o   = word_i ? prod[15] : prod[7];
   // parity looks at the low byte only, even count sets it
   assign parity_o = ~^prod[7:0];
endmodule : and_flag_unit

// [tb/fetch_mem_model.sv]
// partner model: instruction byte stream and operand memory
// assumes the bench loads one instruction of up to six bytes at a time
`timescale 1ns/100ps
module fetch_mem_model
#(
   parameter logic [15:0] MEM_WORD = 16'h5a3c
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        load_i,
   input  wire logic [7:0]  prog_i [0:5],
   input  wire logic [2:0]  len_i,
   input  wire logic        byte_take_i,
   input  wire logic        mem_rd_i,
   output logic             byte_valid_o,
   output logic [7:0]       byte_o,
   output logic [15:0]      mem_rd_data_o
);
   logic [2:0]  ptr_ff;
   logic [2:0]  cnt_ff;
   logic [7:0]  last_ff;
   // ==========================================
   // fetch side
   // idle bus shows the inverse of the last byte, so a stale read is caught
   assign byte_valid_o = (ptr_ff < cnt_ff);
   assign byte_o       = byte_valid_o ? prog_i[ptr_ff] : ~last_ff;
   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i || load_i)
      begin
         ptr_ff <= 3'h0;
         cnt_ff <= rst_b_i ? len_i : 3'h0;
      end
      else if (byte_take_i && byte_valid_o)
      begin
         ptr_ff  <= ptr_ff + 3'h1;
         last_ff <= byte_o;
      end
   end
   // ==========================================
   // operand memory
   // answers while the read pulse stands; idle shows the inverse word
   assign mem_rd_data_o = mem_rd_i ? MEM_WORD : ~MEM_WORD;
endmodule : fetch_mem_model

// [tb/logical_and_and_short_branches_bench.sv]
// bench: AND forms and short conditional branches
// assumes the design package and the fetch/memory partner model
`timescale 1ns/100ps
module logical_and_and_short_branches_bench
   import and_branch_pkg::*;
;
   logic        clk, rst_b, load, byte_valid, byte_take, mem_rd, mem_wr, mem_word, reg_wr, wr_word, flag_wr;
   logic        cy_o, ov_o, z_o, s_o, p_o, taken, illegal, done;
   logic        seen_reg, seen_mem, seen_flag, seen_taken, c_word, c_z, c_s, c_p, c_cy, c_ov;
   logic [7:0]  byte_v;
   logic [7:0]  prog [0:5];
   logic [2:0]  len, rd_idx, wr_idx, ilen, c_idx;
   logic [1:0]  mem_mod;
   logic [2:0]  mem_rm;
   logic [3:0]  fl;
   logic [15:0] regs [0:7];
   logic [15:0] count_reg, mem_data, wr_data, mem_disp, mem_wr_data, pc, exp_pc, c_data, c_mdata;
   int          fails, total_checks;
   // ==========================================
   // instances
   and_branch_exec and_branch_exec_inst (.clk_i(clk), .rst_b_i(rst_b), .byte_valid_i(byte_valid), .byte_i(byte_v),
      .byte_take_o(byte_take), .reg_rd_data_i(regs[rd_idx]), .count_register_i(count_reg), .carry_flag_i(fl[0]),
      .zero_flag_i(fl[1]), .sign_flag_i(fl[2]), .ovf_flag_i(fl[3]), .mem_rd_data_i(mem_data), .reg_rd_idx_o(rd_idx),
      .reg_wr_o(reg_wr), .reg_wr_idx_o(wr_idx), .reg_wr_word_o(wr_word), .reg_wr_data_o(wr_data), .mem_rd_o(mem_rd),
      .mem_wr_o(mem_wr), .mem_word_o(mem_word), .mem_mod_o(mem_mod), .mem_rm_o(mem_rm), .mem_disp_o(mem_disp),
      .mem_wr_data_o(mem_wr_data), .flag_wr_o(flag_wr), .carry_flag_o(cy_o), .ovf_flag_o(ov_o), .zero_flag_o(z_o),
      .sign_flag_o(s_o), .parity_flag_o(p_o), .program_counter_o(pc), .branch_taken_o(taken),
      .illegal_o(illegal), .insn_len_o(ilen), .done_o(done));
   fetch_mem_model fetch_mem_model_inst (.clk_i(clk), .rst_b_i(rst_b), .load_i(load), .prog_i(prog), .len_i(len),
      .byte_take_i(byte_take), .mem_rd_i(mem_rd), .byte_valid_o(byte_valid), .byte_o(byte_v),
      .mem_rd_data_o(mem_data));
   // ==========================================
   // pulse capture, cleared when the next instruction is loaded
   always @(posedge clk)
   begin
      if (load)
      begin
         {seen_reg, seen_mem, seen_flag, seen_taken} <= 4'h0;
      end
      if (reg_wr)
      begin
         {seen_reg, c_idx, c_word, c_data} <= {1'b1, wr_idx, wr_word, wr_data};
      end
      if (mem_wr)
      begin
         {seen_mem, c_mdata} <= {1'b1, mem_wr_data};
      end
      if (flag_wr)
      begin
         {seen_flag, c_z, c_s, c_p, c_cy, c_ov} <= {1'b1, z_o, s_o, p_o, cy_o, ov_o};
      end
      if (taken)
      begin
         seen_taken <= 1'b1;
      end
   end
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic complete_run;
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // one instruction; pc expected to move by its length plus jump
   task automatic run_insn(input logic [7:0] b0, b1, b2, b3, input logic [2:0] n, input logic [15:0] jump);
      logic got;
      got = 1'b0;
      prog = '{b0, b1, b2, b3, 8'h00, 8'h00};
      len = n;
      @(posedge clk) #1 load = 1'b1;
      @(posedge clk) #1 load = 1'b0;
      repeat (30)
      begin
         @(posedge clk) #1;
         if (done === 1'b1 && !got)
         begin
            got = 1'b1;
            break;
         end
      end
      @(posedge clk) #1;
      exp_pc = exp_pc + 16'(n) + jump;
      chk(got, "no completion");
      chk(ilen === n && pc === exp_pc, "length or pc");
   endtask : run_insn
   task automatic and_chk(input logic [2:0] idx, input logic w, input logic [15:0] r);
      logic [15:0] m;
      m = w ? r : {8'h00, r[7:0]};
      chk(seen_reg === 1'b1 && c_idx === idx && c_word === w && c_data === m, "and result");
      chk(seen_flag === 1'b1 && c_z === (m == 16'h0) && c_s === (w ? m[15] : m[7]) && c_p === ~^m[7:0], "flags");
      chk(c_cy === 1'b0 && c_ov === 1'b0 && seen_taken === 1'b0, "and carry");
   endtask : and_chk
   task automatic and_scenario;
      regs[0] = 16'hf0f3;
      run_insn(8'h24, 8'h3c, 8'h00, 8'h00, 3'h2, 16'h0);
      and_chk(ACC_IDX, 1'b0, 16'h0030);
      run_insn(8'h25, 8'h0f, 8'h80, 8'h00, 3'h3, 16'h0);
      and_chk(ACC_IDX, 1'b1, 16'h8003);
      regs[3] = 16'h00ff;
      regs[1] = 16'hff00;
      run_insn(8'h23, 8'hd9, 8'h00, 8'h00, 3'h2, 16'h0);
      and_chk(3'h3, 1'b1, 16'h0000);
      regs[2] = 16'h1234;
      run_insn(8'h83, 8'he2, 8'h80, 8'h00, 3'h3, 16'h0);
      and_chk(3'h2, 1'b1, 16'h1200);
      regs[5] = 16'hffff;
      run_insn(8'h81, 8'he5, 8'h34, 8'h12, 3'h4, 16'h0);
      and_chk(3'h5, 1'b1, 16'h1234);
      regs[1] = 16'h0ff0;
      run_insn(8'h21, 8'h0e, 8'h10, 8'h00, 3'h4, 16'h0);
      chk(seen_mem === 1'b1 && c_mdata === 16'h0a30 && mem_rm === RM_DIRECT && mem_disp === 16'h0010, "mem");
      run_insn(8'h80, 8'h67, 8'h80, 8'h0f, 3'h4, 16'h0);
      chk(seen_mem === 1'b1 && c_mdata[7:0] === 8'h0c && mem_disp === 16'hff80 && mem_word === 1'b0, "imm");
   endtask : and_scenario
   function automatic logic cond(input logic [7:0] op, input logic [3:0] f, input logic [15:0] cw);
      case (op)
         OP_JC:   return f[0];
         OP_JNC:  return !f[0];
         OP_JZ:   return f[1];
         OP_JA:   return !(f[0] | f[1]);
         OP_JS:   return f[2];
         OP_JL:   return f[2] ^ f[3];
         OP_JGE:  return !(f[2] ^ f[3]);
         OP_JLE:  return (f[2] ^ f[3]) | f[1];
         OP_JG:   return !((f[2] ^ f[3]) | f[1]);
         default: return cw == 16'h0;
      endcase
   endfunction : cond
   task automatic branch_scenario;
      logic [7:0] ops [0:9];
      logic [7:0] d;
      logic       t;
      ops = '{OP_JC, OP_JNC, OP_JZ, OP_JA, OP_JS, OP_JL, OP_JGE, OP_JLE, OP_JG, OP_JCXZ};
      for (int k = 0; k < 10; k++)
      begin
         for (int f = 0; f < 16; f++)
         begin
            fl = f[3:0];
            count_reg = f[0] ? 16'h0000 : 16'h8000;
            d = f[1] ? 8'h80 : 8'h7f;
            t = cond(ops[k], fl, count_reg);
            run_insn(ops[k], d, 8'h00, 8'h00, 3'h2, t ? {{8{d[7]}}, d} : 16'h0);
            chk(seen_taken === t, "branch decision");
            chk(seen_flag === 1'b0 && seen_reg === 1'b0, "branch side effect");
         end
      end
   endtask : branch_scenario
   // ==========================================
   // clock, watchdog, main sequence
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #(25 * 6000);
      fails++;
      complete_run();
   end
   initial
   begin
      {rst_b, load, fl, count_reg, len, exp_pc} = '0;
      prog = '{default: 8'h00};
      regs = '{default: 16'h0000};
      fails = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      exp_pc = PC_RESET;
      and_scenario();
      branch_scenario();
      complete_run();
   end
endmodule : logical_and_and_short_branches_bench
